// ---- core/csd_map.vh ----
`ifndef CSD_MAP_VH
`define CSD_MAP_VH
// Register index of the group D configuration word and its companions.
`define ADDR_SELECT_CONFIG  4'h0
`define ADDR_CONTROL_ONE    4'h1
`define ADDR_BASE           4'h2
`define ADDR_STATUS         4'h3
// Field positions of the configuration word.
`define CFG_EN_BIT          0
`define CFG_SIZE_LO         1
`define CFG_SIZE_HI         3
`define CFG_WAIT_LO         4
`define CFG_WAIT_HI         6
`define CFG_WIDTH_BIT       7
`define CFG_FLASH_BIT       8
`define CFG_DRAM_BIT        9
`define CFG_RESET           16'h0200
// Field positions of the companion control word.
`define CTL_LARGE_DRAM_BIT  6
`define CTL_WAIT_LSB_BIT    11
`define CTL_RESET           16'h0000
`define BASE_RESET          16'h0000
// Wait code that hands termination to the external acknowledge.
`define WAIT_EXTERNAL       3'h7
// Log2 of the smallest region, 32K bytes.
`define SIZE_MIN_LOG2       5'h0F
`define SIZE_LARGE_LOG2     5'h17
// Log2 of the smallest region of groups A and B, 128K bytes.
`define SIZE_AB_MIN_LOG2    5'h11
`endif

// ---- core/csd_decode.v ----
`timescale 1ns/10ps
`include "csd_map.vh"
// Computes the log2 of the region size and the wait-state count.
// SMALL_REGIONS is 1 for groups C and D and 0 for the 128K groups A and B.
module csd_decode #(
   parameter SMALL_REGIONS = 1
) (
   input  wire [2:0] size_code,
   input  wire       large_dram,
   input  wire       size_ext,
   input  wire [2:0] wait_upper,
   input  wire       wait_lsb,
   output reg  [4:0] size_log2,
   output reg  [3:0] wait_states,
   output wire       wait_external
);
   always @* begin
      if (SMALL_REGIONS == 0)
         size_log2 = `SIZE_AB_MIN_LOG2 + {2'h0, size_code};   // [R9]
      else if (large_dram && size_code[2:1] == 2'h0)          // [R10]
         size_log2 = `SIZE_LARGE_LOG2 + {4'h0, size_code[0]};
      else
         size_log2 = `SIZE_MIN_LOG2 + {2'h0, size_code};      // [R10]
      if (size_ext)
         size_log2 = size_log2 + 5'h01;                       // [R2]
      wait_states = {wait_upper, wait_lsb};                   // [R4] [R5]
   end
   assign wait_external = (wait_upper == `WAIT_EXTERNAL);     // [R7]
endmodule

// ---- core/csd_control.v ----
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`include "csd_map.vh"
// What the document requires
// [R1] Flash bit 0 drives select and strobes together; 1 leads by a clock.
// [R2] In DRAM mode the flash bit is an extra size bit doubling the region.
// [R3] Bus width bit 0 runs 8-bit accesses and 1 runs 16-bit accesses.
// [R4] The wait count is the 3-bit field above a low bit from control one.
// [R5] Codes 000 to 110 insert twice the code plus the low bit in waits.
// [R6] After the wait states elapse the internal acknowledge ends the cycle.
// [R7] Code 111 waits for the external acknowledge instead of counting.
// [R8] Software must route the shared port pin to the acknowledge itself.
// [R9] Groups A and B decode 128K doubling per step up to 16 Mbyte.
// [R10] C and D decode 32K up to 4 Mbyte, or 8 and 16 Mbyte as large DRAM.
// [R11] The enable bit is write-only; 0 disables and 1 enables the select.
// [R12] The DRAM bit beats flash and turns the pins into address strobes.
// [R13] A select needs the enable and an address in the base-aligned window.
module csd_control (
   input  wire        MCLK,
   input  wire        RSTN,
   input  wire [3:0]  REG_ADDR,
   input  wire [15:0] REG_WDATA,
   input  wire        REG_WR,
   input  wire        REG_RD,
   output reg  [15:0] REG_RDATA,
   input  wire        BUS_REQ,
   input  wire        BUS_WRITE,
   input  wire [23:0] BUS_ADDR,
   input  wire [1:0]  BUS_BYTES,
   input  wire        EXT_ACK,
   output reg         BUS_ACK,
   output reg         SELECT_N,
   output reg  [1:0]  BYTE_WRITE_STROBES_N,
   output reg         ROW_STROBE_N,
   output reg         COL_STROBE_N,
   output reg         WIDE_BUS
);
   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_LEAD = 4'h2;
   localparam [3:0] ST_WAIT = 4'h4;
   localparam [3:0] ST_DONE = 4'h8;

   reg  [15:0] select_config;
   reg  [15:0] control_one;
   reg  [15:0] base_addr;
   reg  [3:0]  state;
   reg  [3:0]  next_state;
   reg  [3:0]  wait_left;
   reg  [3:0]  next_wait_left;
   reg  [15:0] next_rdata;
   wire [4:0]  size_log2;
   wire [3:0]  wait_states;
   wire        wait_external;
   wire        dram_mode;
   wire        flash_mode;
   wire        enabled;
   wire        hit;

   function in_window;
      input [23:0] addr;
      input [15:0] base;
      input [4:0]  lg;
      reg   [23:0] mask;
      begin
         mask = 24'hFFFFFF << lg;
         in_window = ((addr & mask) == ({base, 8'h00} & mask));
      end
   endfunction

   assign dram_mode  = select_config[`CFG_DRAM_BIT];
   assign flash_mode = select_config[`CFG_FLASH_BIT] & ~dram_mode; // [R12]
   assign enabled    = select_config[`CFG_EN_BIT];

   csd_decode #(.SMALL_REGIONS(1)) u_decode (
      .size_code     (select_config[`CFG_SIZE_HI:`CFG_SIZE_LO]),
      .large_dram    (control_one[`CTL_LARGE_DRAM_BIT] & dram_mode),
      .size_ext      (select_config[`CFG_FLASH_BIT] & dram_mode), // [R2]
      .wait_upper    (select_config[`CFG_WAIT_HI:`CFG_WAIT_LO]),
      .wait_lsb      (control_one[`CTL_WAIT_LSB_BIT]),
      .size_log2     (size_log2),
      .wait_states   (wait_states),
      .wait_external (wait_external)
   );

   assign hit = enabled && in_window(BUS_ADDR, base_addr, size_log2); // [R13]

   always @(posedge MCLK) begin
      if (!RSTN) begin
         select_config <= `CFG_RESET;
         control_one   <= `CTL_RESET;
         base_addr     <= `BASE_RESET;
      end else if (REG_WR) begin
         case (REG_ADDR)
            `ADDR_SELECT_CONFIG: select_config <= REG_WDATA; // [R11]
            `ADDR_CONTROL_ONE:   control_one   <= REG_WDATA;
            `ADDR_BASE:          base_addr     <= REG_WDATA;
            default: ;
         endcase
      end
   end

   always @* begin
      case (REG_ADDR)
         `ADDR_SELECT_CONFIG: begin
            // The enable bit is write-only and reads back as zero.
            next_rdata = {select_config[15:1], 1'b0}; // [R11]
         end
         `ADDR_CONTROL_ONE: next_rdata = control_one;
         `ADDR_BASE:        next_rdata = base_addr;
         `ADDR_STATUS:      next_rdata = {12'h000, state};
         default:           next_rdata = 16'h0000;
      endcase
   end

   always @(posedge MCLK) begin
      if (!RSTN)
         REG_RDATA <= 16'h0000;
      else if (REG_RD)
         REG_RDATA <= next_rdata;
      else
         REG_RDATA <= 16'h0000;
   end

   always @* begin
      next_state     = state;
      next_wait_left = wait_left;
      case (state)
         ST_IDLE: begin
            if (BUS_REQ && hit) begin
               next_wait_left = wait_states; // [R5]
               if (flash_mode && BUS_WRITE)
                  next_state = ST_LEAD; // [R1]
               else
                  next_state = ST_WAIT;
            end
         end
         ST_LEAD: next_state = ST_WAIT; // [R1]
         ST_WAIT: begin
            if (wait_external) begin
               if (EXT_ACK)
                  next_state = ST_DONE; // [R7] [R8]
            end else if (wait_left == 4'h0) begin
               next_state = ST_DONE; // [R6]
            end else begin
               next_wait_left = wait_left - 4'h1;
            end
         end
         ST_DONE: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   always @(posedge MCLK) begin
      if (!RSTN) begin
         state                <= ST_IDLE;
         wait_left            <= 4'h0;
         BUS_ACK              <= 1'b0;
         SELECT_N             <= 1'b1;
         BYTE_WRITE_STROBES_N <= 2'h3;
         ROW_STROBE_N         <= 1'b1;
         COL_STROBE_N         <= 1'b1;
         WIDE_BUS             <= 1'b0;
      end else begin
         state     <= next_state;
         wait_left <= next_wait_left;
         BUS_ACK   <= (state == ST_WAIT) && (next_state == ST_DONE); // [R6]
         WIDE_BUS  <= select_config[`CFG_WIDTH_BIT]; // [R3]
         if (dram_mode) begin
            SELECT_N     <= 1'b1; // [R12]
            ROW_STROBE_N <= ~(next_state != ST_IDLE && next_state != ST_DONE);
            COL_STROBE_N <= ~(next_state == ST_WAIT);
         end else begin
            SELECT_N     <= ~(next_state != ST_IDLE && next_state != ST_DONE);
            ROW_STROBE_N <= 1'b1;
            COL_STROBE_N <= 1'b1;
         end
         if (BUS_WRITE && next_state == ST_WAIT) begin
            // An 8-bit region uses only the low strobe.
            if (select_config[`CFG_WIDTH_BIT])
               BYTE_WRITE_STROBES_N <= ~BUS_BYTES; // [R1] [R3]
            else
               BYTE_WRITE_STROBES_N <= 2'h2; // [R3]
         end else begin
            BYTE_WRITE_STROBES_N <= 2'h3;
         end
      end
   end
endmodule

// ---- sim/csd_props.sv ----
`timescale 1ns/10ps
`include "csd_map.vh"
module csd_props (
   input wire        MCLK,
   input wire        RSTN,
   input wire [3:0]  REG_ADDR,
   input wire        REG_RD,
   input wire [15:0] REG_RDATA,
   input wire        BUS_REQ,
   input wire        BUS_ACK,
   input wire        SELECT_N,
   input wire [1:0]  BYTE_WRITE_STROBES_N,
   input wire        ROW_STROBE_N,
   input wire        WIDE_BUS
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RSTN);
   sequence ack_end;
      BUS_ACK ##1 (SELECT_N && !BUS_ACK);
   endsequence
   ack_end_a: assert property (BUS_ACK |-> ack_end)
      else $error("ack not a one cycle end of select");
   ack_cause_a: assert property (BUS_ACK |-> $past(BUS_REQ))
      else $error("ack without request");
   select_hold_a: assert property (!SELECT_N |=> !SELECT_N || BUS_ACK)
      else $error("select dropped before ack");
   select_cause_a: assert property ($fell(SELECT_N) |-> $past(BUS_REQ))
      else $error("select without request");
   pins_exclusive_a: assert property (!SELECT_N |-> ROW_STROBE_N)
      else $error("select and row strobe together");
   strobe_in_select_a: assert property
      (BYTE_WRITE_STROBES_N != 2'b11 |-> !SELECT_N)
      else $error("write strobe outside select");
   narrow_lane_a: assert property
      (!WIDE_BUS |-> BYTE_WRITE_STROBES_N[1])
      else $error("upper strobe on narrow bus");
   enable_hidden_a: assert property
      ($past(REG_RD) && $past(REG_ADDR) == `ADDR_SELECT_CONFIG
       |-> !REG_RDATA[`CFG_EN_BIT])
      else $error("enable bit read back");
endmodule
bind csd_control csd_props props_u (.MCLK(MCLK), .RSTN(RSTN),
   .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
   .BUS_REQ(BUS_REQ), .BUS_ACK(BUS_ACK), .SELECT_N(SELECT_N),
   .BYTE_WRITE_STROBES_N(BYTE_WRITE_STROBES_N),
   .ROW_STROBE_N(ROW_STROBE_N), .WIDE_BUS(WIDE_BUS));

// ---- sim/mem_model.sv ----
`timescale 1ns/10ps
// Answers a selected cycle with an acknowledge after dly plus one clocks.
module mem_model (
   input  wire       MCLK,
   input  wire       RSTN,
   input  wire       SELECT_N,
   input  wire [7:0] dly,
   output reg        EXT_ACK
);
   reg [7:0] cnt;
   always @(posedge MCLK) begin
      if (!RSTN || SELECT_N) begin
         cnt <= 8'h00;
         EXT_ACK <= 1'b0;
      end else if (cnt == dly) begin
         EXT_ACK <= 1'b1;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
module testbench;
   reg         MCLK = 1'b0, RSTN = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
   reg         BUS_REQ = 1'b0, BUS_WRITE = 1'b0;
   reg  [3:0]  REG_ADDR = 4'h0;
   reg  [15:0] REG_WDATA = 16'h0000;
   reg  [23:0] BUS_ADDR = 24'h000000;
   reg  [7:0]  dly = 8'h00;
   reg  [3:0]  ws;
   reg  [1:0]  BUS_BYTES = 2'h3;
   wire        EXT_ACK, BUS_ACK, SELECT_N, ROW_STROBE_N, COL_STROBE_N;
   wire        WIDE_BUS;
   wire [1:0]  BYTE_WRITE_STROBES_N;
   wire [15:0] REG_RDATA;
   integer     fails = 0, checked = 0, cyc = 0, l0, l1, n, lag, k;
   csd_control dut_u (.MCLK(MCLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
      .REG_RDATA(REG_RDATA), .BUS_REQ(BUS_REQ), .BUS_WRITE(BUS_WRITE),
      .BUS_ADDR(BUS_ADDR), .BUS_BYTES(BUS_BYTES), .EXT_ACK(EXT_ACK),
      .BUS_ACK(BUS_ACK), .SELECT_N(SELECT_N), .WIDE_BUS(WIDE_BUS),
      .BYTE_WRITE_STROBES_N(BYTE_WRITE_STROBES_N),
      .ROW_STROBE_N(ROW_STROBE_N), .COL_STROBE_N(COL_STROBE_N));
   mem_model mem_u (.MCLK(MCLK), .RSTN(RSTN), .SELECT_N(SELECT_N),
      .dly(dly), .EXT_ACK(EXT_ACK));
   initial forever #2.5 MCLK = ~MCLK;
   task stop_test;
      begin
         if (fails == 0 && checked > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   always @(posedge MCLK) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         fails = fails + 1;
         stop_test;
      end
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task wr(input [3:0] a, input [15:0] d);
      begin
         @(posedge MCLK);
         REG_ADDR <= a;
         REG_WDATA <= d;
         REG_WR <= 1'b1;
         @(posedge MCLK);
         REG_WR <= 1'b0;
      end
   endtask
   task rd(input [3:0] a, input [15:0] e);
      begin
         @(posedge MCLK);
         REG_ADDR <= a;
         REG_RD <= 1'b1;
         @(posedge MCLK);
         REG_RD <= 1'b0;
         @(negedge MCLK);
         chk(REG_RDATA, e);
      end
   endtask
   // Runs one access; n is 60 when no acknowledge came.
   task acc(input w, input [23:0] a);
      integer s, t;
      begin
         @(posedge MCLK);
         BUS_REQ <= 1'b1;
         BUS_WRITE <= w;
         BUS_ADDR <= a;
         n = 0;
         s = -1;
         t = -1;
         ws = 4'hF;
         while (!BUS_ACK && n < 60) begin
            @(posedge MCLK);
            n = n + 1;
            if (s < 0 && !SELECT_N)
               s = n;
            if (t < 0 && BYTE_WRITE_STROBES_N != 2'b11)
               t = n;
            ws = ws & {COL_STROBE_N, ROW_STROBE_N, BYTE_WRITE_STROBES_N};
         end
         BUS_REQ <= 1'b0;
         lag = t - s;
         repeat (2) @(posedge MCLK);
      end
   endtask
   task t_regs_and_waits;
      begin
         rd(4'h0, 16'h0200);
         rd(4'h3, 16'h0001);
         rd(4'h9, 16'h0000);
         wr(4'h2, 16'h0000);
         acc(0, 24'h000000);
         chk(n, 60);
         wr(4'h0, 16'h0001);
         acc(0, 24'h007FFF);
         l0 = n;
         chk(n, 3);
         acc(0, 24'h008000);
         chk(n, 60);
         for (k = 1; k < 14; k = k + 1) begin
            wr(4'h1, {4'h0, k[0], 11'h000});
            wr(4'h0, {9'h000, k[3:1], 4'h1});
            acc(0, 24'h000100);
            chk(n, l0 + k);
         end
         wr(4'h1, 16'h0000);
      end
   endtask
   task t_lanes_and_sizes;
      begin
         wr(4'h0, 16'h0081);
         acc(1, 24'h000000);
         l1 = n;
         chk(n, 3);
         chk(lag, 0);
         chk(ws, 4'hC);
         chk(WIDE_BUS, 1);
         BUS_BYTES <= 2'h2;
         acc(1, 24'h000000);
         chk(ws, 4'hD);
         BUS_BYTES <= 2'h3;
         wr(4'h0, 16'h0101);
         acc(1, 24'h000000);
         chk(lag, 1);
         chk(n, l1 + 1);
         chk(ws, 4'hE);
         chk(WIDE_BUS, 0);
         wr(4'h0, 16'h000F);
         acc(0, 24'h3FFFFF);
         chk(n, l0);
         acc(0, 24'h400000);
         chk(n, 60);
         wr(4'h1, 16'h0040);
         wr(4'h0, 16'h0203);
         acc(0, 24'hFFFFFF);
         chk(ws[2], 0);
         chk(ws[3], 0);
         wr(4'h1, 16'h0000);
         wr(4'h0, 16'h030F);
         acc(0, 24'h7FFFFF);
         chk(ws[2], 0);
         acc(0, 24'h800000);
         chk(n, 60);
      end
   endtask
   task t_external_ack;
      begin
         wr(4'h0, 16'h0071);
         dly <= 8'h02;
         acc(0, 24'h000000);
         l1 = n;
         chk(n, 6);
         dly <= 8'h07;
         acc(0, 24'h000000);
         chk(n, l1 + 5);
         dly <= 8'h00;
         wr(4'h0, 16'h0061);
         acc(0, 24'h000000);
         chk(n, l0 + 12);
         rd(4'h0, 16'h0060);
         wr(4'h0, 16'h0060);
         acc(0, 24'h000000);
         chk(n, 60);
      end
   endtask
   initial begin
      repeat (2) @(posedge MCLK);
      RSTN <= 1'b1;
      t_regs_and_waits;
      t_lanes_and_sizes;
      t_external_ack;
      stop_test;
   end
endmodule
